// ===== core/slsc_defs.vh
`ifndef SLSC_DEFS_VH
`define SLSC_DEFS_VH

// ------------------------------------------------------------
// register indices (byte address is four times the index)
// ------------------------------------------------------------
`define SLSC_IDX_W 12
`define SLSC_IDX_STRATEGY 12'h30e
`define SLSC_IDX_LOOKUP0 12'h310
`define SLSC_IDX_APPLIED 12'h318
`define SLSC_ADDR_W 14
`define SLSC_ALIGN_OK 2'h0

// ------------------------------------------------------------
// field positions
// ------------------------------------------------------------
`define SLSC_STRAT_SHAPER 1
`define SLSC_STRAT_POLICER 0
`define SLSC_LUE0_VLAN_EN 7
`define SLSC_LUE0_DROP_INV 6
`define SLSC_LUE0_AGE_HI 5
`define SLSC_LUE0_AGE_LO 3
`define SLSC_LUE0_RSVD_MC 2
`define SLSC_LUE0_HASH_HI 1
`define SLSC_LUE0_HASH_LO 0
`define SLSC_APP_SHAPER 9
`define SLSC_APP_POLICER 8

// ------------------------------------------------------------
// reset values
// ------------------------------------------------------------
`define SLSC_RST_SHAPER 1'h0
`define SLSC_RST_POLICER 1'h1
`define SLSC_RST_VLAN_EN 1'h0
`define SLSC_RST_DROP_INV 1'h1
`define SLSC_RST_AGE 3'h4
`define SLSC_RST_RSVD_MC 1'h0
`define SLSC_RST_HASH 2'h1

// ------------------------------------------------------------
// hash select codes
// ------------------------------------------------------------
`define SLSC_HASH_DIRECT 2'h0
`define SLSC_HASH_CRC 2'h1
`define SLSC_HASH_XOR 2'h2
`define SLSC_HASH_DIRECT_ALT 2'h3
`define SLSC_CRC10_POLY 10'h233
`define SLSC_CRC10_INIT 10'h3ff

// ------------------------------------------------------------
// vlan decision codes
// ------------------------------------------------------------
`define SLSC_VACT_PASS 3'h0
`define SLSC_VACT_FWD 3'h1
`define SLSC_VACT_DROP 3'h2
`define SLSC_VACT_HOST 3'h3
`define SLSC_VACT_UNKNOWN 3'h4

// ------------------------------------------------------------
// credit overhead per frame, in bytes
// ------------------------------------------------------------
`define SLSC_IPG_BYTES 16'h000c
`define SLSC_PREAMBLE_BYTES 16'h0008
`define SLSC_ZERO_BYTES 16'h0000

`endif

// ===== core/slsc_hash.v
`timescale 1ns/10ps
`include "slsc_defs.vh"

module slsc_hash (
	input wire [47:0] dst_addr,
	input wire [1:0] address_hash_select,
	output reg [9:0] table_index
);

// ------------------------------------------------------------
// crc and xor folds of the destination address
// ------------------------------------------------------------
// bitwise crc-10, msb first; fine for a one-cycle lookup at 200 mhz
function [9:0] crc10;
	input [47:0] data;
	integer i;
	reg [9:0] c;
	reg fb;
	begin
		c = `SLSC_CRC10_INIT;
		for (i = 47; i >= 0; i = i - 1) begin
			fb = c[9] ^ data[i];
			c = {c[8:0], 1'b0};
			if (fb) begin
				c = c ^ `SLSC_CRC10_POLY;
			end
		end
		crc10 = c;
	end
endfunction

wire [9:0] xor_index;
// top eight bits are zero-extended into the last slice
assign xor_index = dst_addr[9:0] ^ dst_addr[19:10] ^ dst_addr[29:20] ^
	dst_addr[39:30] ^ {2'h0, dst_addr[47:40]};

// ------------------------------------------------------------
// index select
// ------------------------------------------------------------
always @* begin
	case (address_hash_select)
		`SLSC_HASH_CRC: table_index = crc10(dst_addr); // [RULE10]
		`SLSC_HASH_XOR: table_index = xor_index; // [RULE11]
		`SLSC_HASH_DIRECT: table_index = dst_addr[9:0]; // [RULE9]
		`SLSC_HASH_DIRECT_ALT: table_index = dst_addr[9:0]; // [RULE9]
		default: table_index = dst_addr[9:0];
	endcase
end

endmodule // slsc_hash

// ===== core/slsc_top.v
// Behaviour
// RULE1: shaper bit set charges data plus gap and preamble, clear charges data only; resets 0.
// RULE2: policer bit set deducts data plus gap and preamble, clear deducts data only; resets 1.
// RULE3: the vlan enable bit gates all vlan forwarding and filtering decisions and resets clear.
// RULE4: software programs the vlan table fully before setting the vlan enable bit.
// RULE5: invalid vlan id frames drop while the drop bit is set (reset), else go to the host.
// RULE6: enabled unknown-vlan forwarding overrides the drop setting for unrecognised vlan ids.
// RULE7: each dynamic entry write or refresh loads the three-bit age count, which resets to 100b.
// RULE8: reserved multicast table is consulted only while its bit is set; resets clear.
// RULE9: hash select 00 or 11 indexes the dynamic table by the ten low destination address bits.
// RULE10: hash select 01, the reset value, maps entries with a crc hash.
// RULE11: hash select 10 maps entries with an xor hash.
// RULE12: reserved strategy bits read as zero and ignore writes.
// RULE13: a setting applies to frames starting after the write, not to frames in progress.
`timescale 1ns/10ps
`include "slsc_defs.vh"

module slsc_top (
	input wire pclk,
	input wire presetn,
	// apb slave
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [13:0] paddr,
	input wire [31:0] pwdata,
	output wire pready,
	output reg [31:0] prdata,
	output reg pslverr,
	// frame start, credit accounting
	input wire frame_start,
	input wire [13:0] frame_len,
	output reg charge_valid,
	output reg [15:0] shaper_charge,
	output reg [15:0] policer_charge,
	// lookup request
	input wire lookup_req,
	input wire [47:0] dst_addr,
	input wire vid_hit,
	input wire unknown_vid_fwd_en,
	input wire rsvd_mc_match,
	output reg lookup_done,
	output reg [9:0] table_index,
	output reg [2:0] vlan_action,
	output reg rsvd_mc_use,
	// dynamic entry update
	input wire entry_update,
	output reg entry_age_valid,
	output reg [2:0] entry_age_count
);

// ------------------------------------------------------------
// apb decode
// ------------------------------------------------------------
wire [11:0] reg_idx;
wire aligned;
wire hit_strategy;
wire hit_lookup0;
wire hit_applied;
wire mapped;
wire setup_phase;
wire write_now;

// register offsets are word indices, so the byte address carries two
// extra low bits that must be zero for a hit
assign reg_idx = paddr[13:2];
assign aligned = (paddr[1:0] == `SLSC_ALIGN_OK);
assign hit_strategy = aligned && (reg_idx == `SLSC_IDX_STRATEGY);
assign hit_lookup0 = aligned && (reg_idx == `SLSC_IDX_LOOKUP0);
assign hit_applied = aligned && (reg_idx == `SLSC_IDX_APPLIED);
// a miss or a misaligned address answers with pslverr and changes nothing
assign mapped = hit_strategy || hit_lookup0 || hit_applied;
assign setup_phase = psel && !penable;
// zero wait states: every access phase completes in its first cycle
assign pready = psel && penable;
assign write_now = psel && penable && pwrite;

// ------------------------------------------------------------
// live configuration registers
// ------------------------------------------------------------
reg shaper_acct;
reg policer_acct;
reg vlan_en;
reg drop_invalid_vid;
reg [2:0] age_count;
reg rsvd_mc_en;
reg [1:0] address_hash_select;

// only bits 1:0 of the strategy word are stored; the rest is dropped
// a write lands only at the access edge, where pready is already high
always @(posedge pclk or negedge presetn) begin
	if (!presetn) begin
		shaper_acct <= `SLSC_RST_SHAPER; // [RULE1]
		policer_acct <= `SLSC_RST_POLICER; // [RULE2]
		vlan_en <= `SLSC_RST_VLAN_EN; // [RULE3]
		drop_invalid_vid <= `SLSC_RST_DROP_INV; // [RULE5]
		age_count <= `SLSC_RST_AGE; // [RULE7]
		rsvd_mc_en <= `SLSC_RST_RSVD_MC; // [RULE8]
		address_hash_select <= `SLSC_RST_HASH; // [RULE10]
	end else if (write_now) begin
		if (hit_strategy) begin
			shaper_acct <= pwdata[`SLSC_STRAT_SHAPER];
			policer_acct <= pwdata[`SLSC_STRAT_POLICER]; // [RULE12]
		end
		if (hit_lookup0) begin
			vlan_en <= pwdata[`SLSC_LUE0_VLAN_EN];
			drop_invalid_vid <= pwdata[`SLSC_LUE0_DROP_INV];
			age_count <= pwdata[`SLSC_LUE0_AGE_HI:`SLSC_LUE0_AGE_LO];
			rsvd_mc_en <= pwdata[`SLSC_LUE0_RSVD_MC];
			address_hash_select <= pwdata[`SLSC_LUE0_HASH_HI:`SLSC_LUE0_HASH_LO];
		end
	end
end

// ------------------------------------------------------------
// applied configuration, captured at frame start
// ------------------------------------------------------------
// a frame keeps the settings seen when it began, so a write made while
// it is in flight cannot change its treatment halfway through
// limitation: one frame is tracked at a time; the next frame start
// overwrites the settings captured for the frame before it
reg ap_shaper;
reg ap_policer;
reg ap_vlan_en;
reg ap_drop_inv;
reg [2:0] ap_age;
reg ap_rsvd_mc;
reg [1:0] ap_hash;

always @(posedge pclk or negedge presetn) begin
	if (!presetn) begin
		ap_shaper <= `SLSC_RST_SHAPER;
		ap_policer <= `SLSC_RST_POLICER;
		ap_vlan_en <= `SLSC_RST_VLAN_EN;
		ap_drop_inv <= `SLSC_RST_DROP_INV;
		ap_age <= `SLSC_RST_AGE;
		ap_rsvd_mc <= `SLSC_RST_RSVD_MC;
		ap_hash <= `SLSC_RST_HASH;
	end else if (frame_start) begin
		ap_shaper <= shaper_acct; // [RULE13]
		ap_policer <= policer_acct;
		ap_vlan_en <= vlan_en;
		ap_drop_inv <= drop_invalid_vid;
		ap_age <= age_count;
		ap_rsvd_mc <= rsvd_mc_en;
		ap_hash <= address_hash_select;
	end
end

// the frame that starts this cycle already uses the live values
// reset values stand in until the first frame start captures settings
wire eff_vlan_en;
wire eff_drop_inv;
wire [2:0] eff_age;
wire eff_rsvd_mc;
wire [1:0] eff_hash;

assign eff_vlan_en = frame_start ? vlan_en : ap_vlan_en; // [RULE13]
assign eff_drop_inv = frame_start ? drop_invalid_vid : ap_drop_inv;
assign eff_age = frame_start ? age_count : ap_age;
assign eff_rsvd_mc = frame_start ? rsvd_mc_en : ap_rsvd_mc;
assign eff_hash = frame_start ? address_hash_select : ap_hash;

// ------------------------------------------------------------
// register read data
// ------------------------------------------------------------
reg [31:0] next_prdata;

// read data is captured in the setup cycle so prdata comes from a flop
// unassigned bits keep the zero default, so reserved bits read as zero
always @* begin
	next_prdata = 32'h00000000;
	if (hit_strategy) begin
		next_prdata[`SLSC_STRAT_SHAPER] = shaper_acct;
		next_prdata[`SLSC_STRAT_POLICER] = policer_acct; // [RULE12]
	end else if (hit_lookup0) begin
		next_prdata[`SLSC_LUE0_VLAN_EN] = vlan_en;
		next_prdata[`SLSC_LUE0_DROP_INV] = drop_invalid_vid;
		next_prdata[`SLSC_LUE0_AGE_HI:`SLSC_LUE0_AGE_LO] = age_count;
		next_prdata[`SLSC_LUE0_RSVD_MC] = rsvd_mc_en;
		next_prdata[`SLSC_LUE0_HASH_HI:`SLSC_LUE0_HASH_LO] = address_hash_select;
	end else if (hit_applied) begin
		// strategy bits sit above the lookup byte, whose layout is reused below
		next_prdata[`SLSC_APP_SHAPER] = ap_shaper;
		next_prdata[`SLSC_APP_POLICER] = ap_policer;
		next_prdata[`SLSC_LUE0_VLAN_EN] = ap_vlan_en;
		next_prdata[`SLSC_LUE0_DROP_INV] = ap_drop_inv;
		next_prdata[`SLSC_LUE0_AGE_HI:`SLSC_LUE0_AGE_LO] = ap_age;
		next_prdata[`SLSC_LUE0_RSVD_MC] = ap_rsvd_mc;
		next_prdata[`SLSC_LUE0_HASH_HI:`SLSC_LUE0_HASH_LO] = ap_hash;
	end
end

always @(posedge pclk or negedge presetn) begin
	if (!presetn) begin
		prdata <= 32'h00000000;
		pslverr <= 1'b0;
	end else if (setup_phase) begin
		prdata <= pwrite ? 32'h00000000 : next_prdata;
		pslverr <= !mapped; // unmapped or misaligned: error, no write
	end
end

// ------------------------------------------------------------
// credit accounting
// ------------------------------------------------------------
wire [15:0] len_ext;
wire [15:0] overhead;
wire [15:0] shaper_extra;
wire [15:0] policer_extra;
wire [15:0] shaper_total;
wire [15:0] policer_total;

assign len_ext = {2'h0, frame_len};
assign overhead = `SLSC_IPG_BYTES + `SLSC_PREAMBLE_BYTES;
assign shaper_extra = shaper_acct ? overhead : `SLSC_ZERO_BYTES; // [RULE1]
assign policer_extra = policer_acct ? overhead : `SLSC_ZERO_BYTES; // [RULE2]

// both totals are formed every cycle; only a frame start loads them
assign shaper_total = len_ext + shaper_extra; // [RULE1]
assign policer_total = len_ext + policer_extra; // [RULE2]

// a 14-bit length plus 20 bytes cannot overflow 16 bits
always @(posedge pclk or negedge presetn) begin
	if (!presetn) begin
		charge_valid <= 1'b0;
		shaper_charge <= 16'h0000;
		policer_charge <= 16'h0000;
	end else begin
		charge_valid <= frame_start;
		if (frame_start) begin
			shaper_charge <= shaper_total; // [RULE1]
			policer_charge <= policer_total; // [RULE2]
		end
	end
end

// ------------------------------------------------------------
// lookup: hash index, vlan decision, reserved multicast
// ------------------------------------------------------------
wire [9:0] hash_index;
wire next_rsvd_mc_use;

// a reserved match alone is not enough; the table must also be enabled
assign next_rsvd_mc_use = eff_rsvd_mc && rsvd_mc_match; // [RULE8]

// the hash mode follows the frame's applied settings, not a mid-frame write
slsc_hash u_hash (
	.dst_addr(dst_addr),
	.address_hash_select(eff_hash),
	.table_index(hash_index)
);

reg [2:0] next_vlan_action;

// unknown-vid forwarding beats the drop bit; vlan off means no decision
always @* begin
	next_vlan_action = `SLSC_VACT_PASS;
	if (!eff_vlan_en) begin
		next_vlan_action = `SLSC_VACT_PASS; // [RULE3]
	end else if (vid_hit) begin
		next_vlan_action = `SLSC_VACT_FWD;
	end else if (unknown_vid_fwd_en) begin
		next_vlan_action = `SLSC_VACT_UNKNOWN; // [RULE6]
	end else if (eff_drop_inv) begin
		next_vlan_action = `SLSC_VACT_DROP; // [RULE5]
	end else begin
		next_vlan_action = `SLSC_VACT_HOST; // [RULE5]
	end
end

always @(posedge pclk or negedge presetn) begin
	if (!presetn) begin
		lookup_done <= 1'b0;
		table_index <= 10'h000;
		vlan_action <= `SLSC_VACT_PASS;
		rsvd_mc_use <= 1'b0;
	end else begin
		lookup_done <= lookup_req;
		if (lookup_req) begin
			table_index <= hash_index; // [RULE9]
			vlan_action <= next_vlan_action; // [RULE3]
			rsvd_mc_use <= next_rsvd_mc_use; // [RULE8]
		end
	end
end

// ------------------------------------------------------------
// age count for dynamic entry writes and refreshes
// ------------------------------------------------------------
// a refresh inside a frame keeps the age that frame began with, so a
// write to the age field never splits one frame across two aging times
always @(posedge pclk or negedge presetn) begin
	if (!presetn) begin
		entry_age_valid <= 1'b0;
		entry_age_count <= `SLSC_RST_AGE;
	end else begin
		entry_age_valid <= entry_update;
		if (entry_update) begin
			entry_age_count <= eff_age; // [RULE7]
		end
	end
end

endmodule // slsc_top

// ===== tb/slsc_top_props.sv
`timescale 1ns/10ps
// ------------------------------------------------------------
// port checks for the lookup and shaper control
// ------------------------------------------------------------
module slsc_props (
	input wire pclk,
	input wire presetn,
	input wire psel,
	input wire penable,
	input wire pready,
	input wire frame_start,
	input wire [13:0] frame_len,
	input wire charge_valid,
	input wire [15:0] shaper_charge,
	input wire [15:0] policer_charge,
	input wire lookup_req,
	input wire vid_hit,
	input wire unknown_vid_fwd_en,
	input wire lookup_done,
	input wire [2:0] vlan_action,
	input wire entry_update,
	input wire entry_age_valid
);
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	// zero wait states, so a write completes at the access edge
	a_ready_zero_wait: assert property (psel && penable |-> pready)
		else $error("pready missing in access");
	a_charge_pulse: assert property (frame_start |=> charge_valid)
		else $error("charge_valid missing");
	// overhead is either zero or gap plus preamble
	a_shaper_amount: assert property (frame_start |=> shaper_charge == $past(frame_len) +
		16'h14 || shaper_charge == $past(frame_len)) else $error("shaper charge wrong");
	a_policer_amount: assert property (frame_start |=> policer_charge == $past(frame_len) +
		16'h14 || policer_charge == $past(frame_len)) else $error("policer charge wrong");
	a_charge_hold: assert property (!frame_start |=> $stable(shaper_charge))
		else $error("shaper charge moved");
	a_lookup_done: assert property (lookup_req |=> lookup_done)
		else $error("lookup_done missing");
	a_done_cause: assert property (lookup_done |-> $past(lookup_req))
		else $error("lookup_done without request");
	a_vlan_hit: assert property (lookup_req && vid_hit |=> vlan_action <= 3'h1)
		else $error("known vid not passed");
	a_vlan_unknown: assert property (lookup_req && !vid_hit && unknown_vid_fwd_en |=>
		vlan_action == 3'h4 || vlan_action == 3'h0) else $error("unknown forward lost");
	a_age_pulse: assert property (entry_update |=> entry_age_valid)
		else $error("entry_age_valid missing");
	c_frame: cover property (frame_start);
	c_miss: cover property (lookup_req && !vid_hit);
	c_age: cover property (entry_update);
endmodule // slsc_props

// ===== tb/slsc_top_bench.sv
`timescale 1ns/10ps
`include "slsc_defs.vh"
// ------------------------------------------------------------
// register and lookup sequences
// ------------------------------------------------------------
module slsc_top_bench;
	logic pclk, presetn, psel, penable, pwrite, frame_start, lookup_req;
	logic vid_hit, unknown_vid_fwd_en, rsvd_mc_match, entry_update;
	logic [13:0] paddr, frame_len;
	logic [31:0] pwdata, rd;
	logic [47:0] dst_addr;
	wire pready, pslverr, charge_valid, lookup_done, rsvd_mc_use, entry_age_valid;
	wire [31:0] prdata;
	wire [15:0] shaper_charge, policer_charge;
	wire [9:0] table_index;
	wire [2:0] vlan_action, entry_age_count;
	integer num_errors, comparisons, m;
	localparam [13:0] A_STR = {`SLSC_IDX_STRATEGY, 2'h0};
	localparam [13:0] A_LU0 = {`SLSC_IDX_LOOKUP0, 2'h0};
	localparam [13:0] A_APP = {`SLSC_IDX_APPLIED, 2'h0};
	localparam [47:0] DA = 48'h0123456789ab;
	slsc_top u_dut (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
		.frame_start(frame_start), .frame_len(frame_len), .charge_valid(charge_valid),
		.shaper_charge(shaper_charge), .policer_charge(policer_charge),
		.lookup_req(lookup_req), .dst_addr(dst_addr), .vid_hit(vid_hit),
		.unknown_vid_fwd_en(unknown_vid_fwd_en), .rsvd_mc_match(rsvd_mc_match),
		.lookup_done(lookup_done), .table_index(table_index), .vlan_action(vlan_action),
		.rsvd_mc_use(rsvd_mc_use), .entry_update(entry_update),
		.entry_age_valid(entry_age_valid), .entry_age_count(entry_age_count)
	);
	// expected index per hash select code
	function logic [9:0] hix(input logic [47:0] a, input integer s);
		logic [9:0] c;
		begin
			c = 10'h3ff;
			for (int i = 47; i >= 0; i--) c = {c[8:0], 1'b0} ^ ((c[9] ^ a[i]) ? 10'h233 : 10'h0);
			hix = (s == 1) ? c : (s == 2) ? a[9:0] ^ a[19:10] ^ a[29:20] ^ a[39:30] ^
				{2'h0, a[47:40]} : a[9:0];
		end
	endfunction
	task chk(input logic [31:0] seen, input logic [31:0] exp);
		begin
			comparisons++;
			if (seen !== exp) begin
				num_errors++;
				$display("ERROR %0t seen %h expected %h", $time, seen, exp);
			end
		end
	endtask
	// one transfer; idle edge after it so back-to-back calls never collide
	task apb(input logic w, input logic [13:0] a, input logic [31:0] d, input logic e);
		begin
			psel <= 1'b1;
			pwrite <= w;
			paddr <= a;
			pwdata <= d;
			@(posedge pclk);
			penable <= 1'b1;
			@(posedge pclk);
			// no cycle count is assumed; only the watchdog ends a stuck wait
			while (pready !== 1'b1) begin
				@(posedge pclk);
			end
			rd = prdata;
			chk({31'h0, pslverr}, {31'h0, e});
			psel <= 1'b0;
			penable <= 1'b0;
			@(posedge pclk);
		end
	endtask
	task rdk(input logic [13:0] a, input logic [31:0] exp);
		begin
			apb(1'b0, a, 32'h0, 1'b0);
			chk(rd, exp);
		end
	endtask
	task frame(input logic [13:0] len, input logic [15:0] s, input logic [15:0] p);
		begin
			frame_start <= 1'b1;
			frame_len <= len;
			@(posedge pclk);
			frame_start <= 1'b0;
			#1;
			chk({charge_valid, shaper_charge}, {1'b1, s});
			chk(policer_charge, p);
			@(posedge pclk);
		end
	endtask
	// lookup and entry update share the edge; the reserved match is always offered
	task look(input logic [1:0] h, input logic [9:0] ix, input logic [2:0] act,
		input logic u, input logic [2:0] g);
		begin
			{lookup_req, entry_update, rsvd_mc_match} <= 3'h7;
			{vid_hit, unknown_vid_fwd_en} <= h;
			dst_addr <= DA;
			@(posedge pclk);
			{lookup_req, entry_update} <= 2'h0;
			#1;
			chk({lookup_done, entry_age_valid, entry_age_count, vlan_action, rsvd_mc_use,
				table_index}, {13'h0, 2'h3, g, act, u, ix});
			@(posedge pclk);
		end
	endtask
	task close_out;
		begin
			$display("errors %0d comparisons %0d", num_errors, comparisons);
			if (num_errors == 0 && comparisons > 0) begin
				$display("Result: passed");
			end else begin
				$display("Result: failed");
			end
			$finish;
		end
	endtask
	// 200 mhz clock
	initial begin
		pclk = 1'b0;
		forever #2.5 pclk = ~pclk;
	end
	// watchdog, far beyond the hundred or so cycles needed
	initial begin
		#20000;
		num_errors++;
		close_out;
	end
	// main sequence
	initial begin
		{psel, penable, pwrite, frame_start, lookup_req, presetn} <= 6'h0;
		{vid_hit, unknown_vid_fwd_en, rsvd_mc_match, entry_update} <= 4'h0;
		{paddr, frame_len, pwdata, dst_addr} <= '0;
		num_errors = 0;
		comparisons = 0;
		repeat (12) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		rdk(A_STR, 32'h1);
		rdk(A_LU0, 32'h61);
		rdk(A_APP, 32'h161);
		look(2'h0, hix(DA, 1), 3'h0, 1'b0, 3'h4);
		apb(1'b1, A_STR, 32'hffffffff, 1'b0);
		rdk(A_STR, 32'h3);
		frame(14'h64, 16'h78, 16'h78);
		apb(1'b1, A_STR, 32'h0, 1'b0);
		frame(14'h3fff, 16'h3fff, 16'h3fff);
		apb(1'b1, A_STR, 32'h1, 1'b0);
		apb(1'b0, 14'h4, 32'h0, 1'b1);
		apb(1'b0, A_LU0 + 14'h1, 32'h0, 1'b1);
		// vlan enabled with drop clear, host port takes misses, every hash code
		for (m = 0; m < 4; m++) begin
			apb(1'b1, A_LU0, 32'h94 | m, 1'b0);
			frame(14'h1, 16'h1, 16'h15);
			look(2'h0, hix(DA, m), 3'h3, 1'b1, 3'h2);
		end
		apb(1'b1, A_LU0, 32'hd4, 1'b0);
		frame(14'h1, 16'h1, 16'h15);
		look(2'h0, DA[9:0], 3'h2, 1'b1, 3'h2);
		look(2'h2, DA[9:0], 3'h1, 1'b1, 3'h2);
		look(2'h1, DA[9:0], 3'h4, 1'b1, 3'h2);
		// new setting waits for the next frame
		apb(1'b1, A_LU0, 32'h61, 1'b0);
		look(2'h0, DA[9:0], 3'h2, 1'b1, 3'h2);
		rdk(A_APP, 32'h1d4);
		frame(14'h1, 16'h1, 16'h15);
		look(2'h0, hix(DA, 1), 3'h0, 1'b0, 3'h4);
		close_out;
	end
endmodule // slsc_top_bench
bind slsc_top slsc_props u_props (.*);
